// [rtl/pmr_top.sv]
// Power mode, wake-up and warm reset control with a Wishbone register slave
// Overview of operation
// - Watchdog firing drives a 96-period high pulse onto the reset pin.
// - Writing the idle request bit makes that write the last before idle.
// - Idle stops only the CPU clock; interrupts, timers, serial keep clocking.
// - Idle preserves all CPU state by freezing, not resetting, the core.
// - Idle freezes port levels and holds both bus strobes high.
// - Enabled interrupt in idle clears idle request bit and ends idle.
// - After that service routine the core resumes after the idle instruction.
// - Two general software flags live in the power control register.
// - Reset held 24 periods ends idle and completes a warm reset.
// - Power-down request stops the oscillator after the requesting write.
// - Power-down keeps internal RAM and special registers unchanged.
// - Power-down ends only by hardware reset or qualifying external wake.
// - Only enabled external zero, one and keyboard sources wake power-down.
// - Keyboard wake waits 1024 clocks before normal operation.
// - Low wake pin restarts oscillator; exit completes when pin returns high.
// - With both pins enabled the first low pin owns the exit.
// - After that service routine the core resumes after power-down entry.
// - Reset exit reinitialises registers; interrupt exit leaves them alone.
// - Idle and power-down both set: same exit, both bits cleared.
`timescale 1ns/10ps
`default_nettype none
`include "pmr_defines.svh"

module pmr_top
   import pmr_pkg::*;
#(
   parameter int WARM_RST_TOSC  = `PMR_WARM_RST_TOSC,
   parameter int WDT_PULSE_TOSC = `PMR_WDT_PULSE_TOSC,
   parameter int KBD_WAKE_TOSC  = `PMR_KBD_WAKE_TOSC
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Core side
   input  wire logic        irq_pending_i,
   input  wire logic        wdt_fire_i,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             osc_en_o,
   output logic             core_reset_o,
   output logic             strobe_hold_hi_o,
   output logic             strobe_hold_lo_o,
   output logic             port_hold_o,
   output logic [1:0]       wake_src_o,
   // Pins
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe_o,
   input  wire logic        ext_irq_zero_n_i,
   input  wire logic        ext_irq_one_n_i,
   input  wire logic        kbd_irq_i
);

   localparam logic [4:0]  RST_CYC = 5'(WARM_RST_TOSC * `PMR_CLK_PER_TOSC);
   localparam logic [6:0]  WDT_CYC = 7'(WDT_PULSE_TOSC * `PMR_CLK_PER_TOSC);
   localparam logic [10:0] KBD_CYC = 11'(KBD_WAKE_TOSC * `PMR_CLK_PER_TOSC);

   pmr_regs_t s_r;
   pmr_regs_t s_nxt;
   pmr_pins_t pin_raw;
   pmr_pins_t pin;
   logic      req;
   logic      wr;
   logic      rst_line;
   logic      wake_ext0;
   logic      wake_ext1;
   logic      wake_kbd;

   assign pin_raw = '{kbd: kbd_irq_i, ext1_n: ext_irq_one_n_i, ext0_n: ext_irq_zero_n_i, rst: rst_pin_i};

   pmr_sync pmr_sync_i
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pins_i (pin_raw),
      .pins_o (pin)
   );

   assign req = wb_cyc_i & wb_stb_i;
   // Write lands on the edge where the master sees ack
   assign wr  = req & s_r.ack & wb_we_i & wb_sel_i[0];
   // own pulse
   // Our own drive counts even if the board wire is slow to show it
   assign rst_line = pin.rst | s_r.wdt_drv;

   assign wake_ext0 = s_r.wake_en[`PMR_WEN_EXT0] & ~pin.ext0_n;
   assign wake_ext1 = s_r.wake_en[`PMR_WEN_EXT1] & ~pin.ext1_n;
   assign wake_kbd  = s_r.wake_en[`PMR_WEN_KBD] & pin.kbd;

   always_comb
   begin
      s_nxt     = s_r;
      s_nxt.ack = req & ~s_r.ack;
      if (req & ~s_r.ack)
      begin
         case (wb_adr_i)
            `PMR_OFS_PCR:     s_nxt.dat = {28'h0, s_r.pcr};
            `PMR_OFS_WAKE_EN: s_nxt.dat = {29'h0, s_r.wake_en};
            `PMR_OFS_STATUS:  s_nxt.dat = {25'h0, s_r.osc_en, s_r.rst_act, s_r.wake_src, s_r.st};
            default:          s_nxt.dat = 32'h0;
         endcase
      end

      // watchdog pulse
      // Not cut short by the warm reset it causes
      if (s_r.wdt_cnt != 7'h0)
      begin
         s_nxt.wdt_cnt = s_r.wdt_cnt - 7'h1;
      end
      else if (wdt_fire_i & s_r.osc_en)
      begin
         s_nxt.wdt_cnt = WDT_CYC;
      end
      s_nxt.wdt_drv = (s_nxt.wdt_cnt != 7'h0);

      // relies on the pin being held for the full count
      if (!rst_line)
      begin
         s_nxt.rst_cnt = 5'h0;
         s_nxt.rst_act = 1'b0;
      end
      else if (s_r.rst_cnt != RST_CYC)
      begin
         s_nxt.rst_cnt = s_r.rst_cnt + 5'h1;
         s_nxt.rst_act = s_r.rst_act | (s_r.rst_cnt == RST_CYC - 5'h1);
      end

      if (s_r.rst_act)
      begin
         s_nxt.st       = PMR_RUN;
         s_nxt.pcr      = `PMR_PCR_RST;
         s_nxt.wake_en  = `PMR_WEN_RST;
         s_nxt.kbd_cnt  = 11'h0;
         s_nxt.wake_src = PMR_SRC_NONE;
         s_nxt.osc_en   = 1'b1;
      end
      else
      begin
         case (s_r.st)
            PMR_RUN:
            begin
               if (wr && wb_adr_i == `PMR_OFS_PCR)
               begin
                  s_nxt.pcr = pmr_pcr_t'(wb_dat_i[3:0]);
                  if (wb_dat_i[`PMR_PCR_PDOWN])
                  begin
                     s_nxt.st     = PMR_PDOWN;
                     s_nxt.osc_en = 1'b0;
                  end
                  else if (wb_dat_i[`PMR_PCR_IDLE])
                  begin
                     s_nxt.st = PMR_IDLE;
                  end
               end
               else if (wr && wb_adr_i == `PMR_OFS_WAKE_EN)
               begin
                  s_nxt.wake_en = wb_dat_i[2:0];
               end
            end
            PMR_IDLE:
            begin
               if (wr && wb_adr_i == `PMR_OFS_PCR)
               begin
                  s_nxt.pcr.gf0 = wb_dat_i[`PMR_PCR_GF0];
                  s_nxt.pcr.gf1 = wb_dat_i[`PMR_PCR_GF1];
               end
               // core state untouched, so it resumes in place
               if (irq_pending_i)
               begin
                  s_nxt.pcr.idle = 1'b0;
                  s_nxt.st       = PMR_RUN;
               end
            end
            PMR_PDOWN:
            begin
               if (wake_ext0)
               begin
                  s_nxt.st       = PMR_WAKE;
                  s_nxt.osc_en   = 1'b1;
                  s_nxt.wake_src = PMR_SRC_EXT0;
               end
               else if (wake_ext1)
               begin
                  s_nxt.st       = PMR_WAKE;
                  s_nxt.osc_en   = 1'b1;
                  s_nxt.wake_src = PMR_SRC_EXT1;
               end
               else if (wake_kbd)
               begin
                  s_nxt.st       = PMR_KBD;
                  s_nxt.osc_en   = 1'b1;
                  s_nxt.kbd_cnt  = KBD_CYC;
                  s_nxt.wake_src = PMR_SRC_KBD;
               end
            end
            PMR_WAKE:
            begin
               // oscillator settles while the pin is held low
               if ((s_r.wake_src == PMR_SRC_EXT0 && pin.ext0_n) ||
                   (s_r.wake_src == PMR_SRC_EXT1 && pin.ext1_n))
               begin
                  // registers kept, core resumes after the entry write
                  s_nxt.st        = PMR_RUN;
                  s_nxt.pcr.idle  = 1'b0;
                  s_nxt.pcr.pdown = 1'b0;
               end
            end
            PMR_KBD:
            begin
               if (s_r.kbd_cnt == 11'h1)
               begin
                  s_nxt.st        = PMR_RUN;
                  s_nxt.pcr.idle  = 1'b0;
                  s_nxt.pcr.pdown = 1'b0;
               end
               s_nxt.kbd_cnt = s_r.kbd_cnt - 11'h1;
            end
            default:
            begin
               s_nxt.st = PMR_RUN;
            end
         endcase
      end

      // core frozen, never reset, while gated
      // everything holds with the clocks stopped
      s_nxt.cpu_clk_en    = (s_nxt.st == PMR_RUN);
      s_nxt.periph_clk_en = (s_nxt.st == PMR_RUN) || (s_nxt.st == PMR_IDLE);
      s_nxt.strobe_hi     = (s_nxt.st == PMR_IDLE);
      s_nxt.strobe_lo     = (s_nxt.st != PMR_RUN) && (s_nxt.st != PMR_IDLE);
      s_nxt.port_hold     = (s_nxt.st != PMR_RUN);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r               <= '0;
         s_r.st            <= PMR_RUN;
         s_r.pcr           <= `PMR_PCR_RST;
         s_r.wake_en       <= `PMR_WEN_RST;
         s_r.cpu_clk_en    <= 1'b1;
         s_r.periph_clk_en <= 1'b1;
         s_r.osc_en        <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o         = s_r.dat;
   assign wb_ack_o         = s_r.ack;
   assign cpu_clk_en_o     = s_r.cpu_clk_en;
   assign periph_clk_en_o  = s_r.periph_clk_en;
   assign osc_en_o         = s_r.osc_en;
   assign core_reset_o     = s_r.rst_act;
   assign strobe_hold_hi_o = s_r.strobe_hi;
   assign strobe_hold_lo_o = s_r.strobe_lo;
   assign port_hold_o      = s_r.port_hold;
   assign wake_src_o       = s_r.wake_src;
   assign rst_pin_o        = s_r.wdt_drv;
   assign rst_pin_oe_o     = s_r.wdt_drv;

   // Length of the current watchdog drive, read only by the checks
   logic [7:0] drv_len_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drv_len_r <= 8'h0;
      end
      else if (s_r.wdt_drv)
      begin
         drv_len_r <= drv_len_r + 8'h1;
      end
      else if (s_nxt.wdt_drv)
      begin
         drv_len_r <= 8'h0;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_wdt_pulse_len: assert property ($fell(rst_pin_oe_o) |-> drv_len_r == 8'(WDT_CYC))
      else $error("watchdog reset pulse has wrong length");

   chk_idle_entry_now: assert property
      (s_r.st == PMR_RUN && !s_r.rst_act && wr && wb_adr_i == `PMR_OFS_PCR
       && wb_dat_i[`PMR_PCR_IDLE] && !wb_dat_i[`PMR_PCR_PDOWN]
       |=> !cpu_clk_en_o && s_r.st == PMR_IDLE)
      else $error("idle not entered right after request write");

   chk_idle_clock_gate: assert property (s_r.st == PMR_IDLE |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o)
      else $error("idle clock gating wrong");

   chk_idle_pins_held: assert property (s_r.st == PMR_IDLE |-> strobe_hold_hi_o && !strobe_hold_lo_o && port_hold_o)
      else $error("idle strobe or port hold wrong");

   chk_idle_irq_exit: assert property
      (s_r.st == PMR_IDLE && !s_r.rst_act && irq_pending_i
       |=> s_r.st == PMR_RUN && !s_r.pcr.idle && cpu_clk_en_o)
      else $error("interrupt did not end idle");

   chk_warm_rst_act: assert property
      (rst_line && s_r.rst_cnt == RST_CYC - 5'h1 |=> core_reset_o ##1 (s_r.st == PMR_RUN || !rst_line))
      else $error("warm reset not taken after full hold");

   chk_rst_release: assert property (!rst_line |=> !core_reset_o)
      else $error("warm reset held after pin release");

   chk_pd_osc_off: assert property (s_r.st == PMR_PDOWN |-> !osc_en_o && !periph_clk_en_o && strobe_hold_lo_o)
      else $error("oscillator running in power-down");

   chk_pd_stays: assert property
      (s_r.st == PMR_PDOWN && !s_r.rst_act && !wake_ext0 && !wake_ext1 && !wake_kbd
       |=> s_r.st == PMR_PDOWN && $stable(s_r.pcr))
      else $error("power-down left without a wake event");

   chk_kbd_wait_len: assert property
      ($changed(s_r.st) && s_r.st == PMR_KBD |-> s_r.kbd_cnt == KBD_CYC && !cpu_clk_en_o)
      else $error("keyboard wake count not loaded");

   chk_ext_held_low: assert property
      (s_r.st == PMR_WAKE && !s_r.rst_act && s_r.wake_src == PMR_SRC_EXT0 && !pin.ext0_n
       |=> s_r.st == PMR_WAKE && osc_en_o && !cpu_clk_en_o)
      else $error("exit completed while wake pin low");

   chk_exit_clears: assert property
      ($past(s_r.st) == PMR_WAKE && s_r.st == PMR_RUN |-> !s_r.pcr.idle && !s_r.pcr.pdown)
      else $error("request bits not cleared on wake exit");

endmodule : pmr_top
`default_nettype wire

// [rtl/pmr_defines.svh]
// Constants for the power mode and reset control block
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

// Register byte offsets
`define PMR_OFS_PCR      8'h00
`define PMR_OFS_WAKE_EN  8'h04
`define PMR_OFS_STATUS   8'h08

// Power control register bit positions
`define PMR_PCR_IDLE     0
`define PMR_PCR_PDOWN    1
`define PMR_PCR_GF0      2
`define PMR_PCR_GF1      3

// Wake enable register bit positions
`define PMR_WEN_EXT0     0
`define PMR_WEN_EXT1     1
`define PMR_WEN_KBD      2

// Reset values
`define PMR_PCR_RST      4'h0
`define PMR_WEN_RST      3'h0
// Pin idle levels: {kbd, ext_irq_one_n, ext_irq_zero_n, reset pin}
`define PMR_PIN_IDLE     4'h6

// Timing, in oscillator periods
`define PMR_WARM_RST_TOSC  24
`define PMR_WDT_PULSE_TOSC 96
`define PMR_KBD_WAKE_TOSC  1024
// clk_i is the oscillator clock itself
`define PMR_CLK_PER_TOSC   1

`endif

// [rtl/pmr_pkg.sv]
// Types of the power mode and reset control block
package pmr_pkg;

   typedef enum logic [2:0]
   {
      PMR_RUN   = 3'h0,
      PMR_IDLE  = 3'h1,
      PMR_PDOWN = 3'h3,
      PMR_WAKE  = 3'h2,
      PMR_KBD   = 3'h6
   } pmr_state_t;

   typedef enum logic [1:0]
   {
      PMR_SRC_NONE = 2'h0,
      PMR_SRC_EXT0 = 2'h1,
      PMR_SRC_EXT1 = 2'h2,
      PMR_SRC_KBD  = 2'h3
   } pmr_src_t;

   typedef struct packed
   {
      logic gf1;
      logic gf0;
      logic pdown;
      logic idle;
   } pmr_pcr_t;

   // Synchronised pins
   typedef struct packed
   {
      logic kbd;
      logic ext1_n;
      logic ext0_n;
      logic rst;
   } pmr_pins_t;

   typedef struct packed
   {
      pmr_pins_t meta;
      pmr_pins_t stable;
   } pmr_sync_t;

   typedef struct packed
   {
      pmr_state_t  st;
      pmr_pcr_t    pcr;
      logic [2:0]  wake_en;
      logic [4:0]  rst_cnt;
      logic        rst_act;
      logic [6:0]  wdt_cnt;
      logic        wdt_drv;
      logic [10:0] kbd_cnt;
      pmr_src_t    wake_src;
      logic        ack;
      logic [31:0] dat;
      logic        cpu_clk_en;
      logic        periph_clk_en;
      logic        osc_en;
      logic        strobe_hi;
      logic        strobe_lo;
      logic        port_hold;
   } pmr_regs_t;

endpackage : pmr_pkg

// [rtl/pmr_sync.sv]
// Two flip-flop synchroniser for the pin inputs
`timescale 1ns/10ps
`default_nettype none
`include "pmr_defines.svh"

module pmr_sync
   import pmr_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   input  wire pmr_pins_t pins_i,
   output var  pmr_pins_t pins_o
);

   pmr_sync_t s_r;
   pmr_sync_t s_nxt;

   always_comb
   begin
      s_nxt.meta   = pins_i;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r.meta   <= `PMR_PIN_IDLE;
         s_r.stable <= `PMR_PIN_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign pins_o = s_r.stable;

endmodule : pmr_sync
`default_nettype wire

// [verif/pmr_pins_model.sv]
// Reset circuitry and wake pins outside the block
`timescale 1ns/10ps
`default_nettype none

module pmr_pins_model
(
   input  wire logic clk_i,
   input  wire logic drive_i,
   input  wire logic drive_oe_i,
   output logic      rst_lvl_o,
   output logic      ext0_n_o,
   output logic      ext1_n_o,
   output logic      kbd_o
);
   logic ext_rst_r;

   // Pull-down on the line, so a released pin reads low
   assign rst_lvl_o = ext_rst_r | (drive_oe_i & drive_i);

   initial
   begin
      ext_rst_r = 1'b0;
      ext0_n_o  = 1'b1;
      ext1_n_o  = 1'b1;
      kbd_o     = 1'b0;
   end

   task automatic hold_reset(input int n);
      @(posedge clk_i);
      ext_rst_r <= 1'b1;
      repeat (n) @(posedge clk_i);
      ext_rst_r <= 1'b0;
   endtask : hold_reset

   task automatic set_pin(input int w, input logic a);
      case (w)
         0: ext0_n_o <= ~a;
         1: ext1_n_o <= ~a;
         default: kbd_o <= a;
      endcase
   endtask : set_pin

   // request held for n clocks, then released
   task automatic pin_low(input int w, input int n);
      @(posedge clk_i);
      set_pin(w, 1'b1);
      repeat (n) @(posedge clk_i);
      set_pin(w, 1'b0);
   endtask : pin_low
endmodule : pmr_pins_model
`default_nettype wire

// [verif/pmr_top_bench.sv]
// Self-checking bench for the power mode and reset block
`timescale 1ns/10ps
`default_nettype none
`include "pmr_defines.svh"

module pmr_top_bench;
   localparam int KBD_N = 8;
   localparam int WDT_N = `PMR_WDT_PULSE_TOSC;
   localparam int RST_N = `PMR_WARM_RST_TOSC;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0;
   logic        irq   = 1'b0;
   logic        wdt   = 1'b0;
   logic [31:0] rdat;
   logic        ack, cpu_en, per_en, osc_en, core_rst, st_hi, st_lo, p_hold;
   logic [1:0]  wsrc;
   logic        pin_o, pin_oe, pin_lvl, e0n, e1n, kbd;
   int          failures = 0;
   int          total_checks = 0;

   always #25 clk_i = ~clk_i;

   pmr_top #(.KBD_WAKE_TOSC(KBD_N)) pmr_top_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_pending_i(irq), .wdt_fire_i(wdt), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
      .osc_en_o(osc_en), .core_reset_o(core_rst), .strobe_hold_hi_o(st_hi),
      .strobe_hold_lo_o(st_lo), .port_hold_o(p_hold), .wake_src_o(wsrc), .rst_pin_i(pin_lvl),
      .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe), .ext_irq_zero_n_i(e0n),
      .ext_irq_one_n_i(e1n), .kbd_irq_i(kbd)
   );

   pmr_pins_model pmr_pins_model_i
   (
      .clk_i(clk_i), .drive_i(pin_o), .drive_oe_i(pin_oe), .rst_lvl_o(pin_lvl),
      .ext0_n_o(e0n), .ext1_n_o(e1n), .kbd_o(kbd)
   );

   task give_verdict;
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // Waits are bounded so a stuck ack cannot hang the run
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n >= 50)
      begin
         failures++;
         $display("FAIL bus ack expected 1 seen %b", ack);
         give_verdict();
      end
   endtask : wb

   task automatic wait_for(input int s, input logic v, output int n);
      logic x;
      n = 0;
      do
      begin
         tick(1);
         n++;
         case (s)
            0: x = cpu_en;
            1: x = osc_en;
            2: x = core_rst;
            default: x = pin_oe;
         endcase
      end
      while (x !== v && n < 2000);
      if (x !== v)
      begin
         failures++;
         $display("FAIL wait %0d expected %b seen %b", s, v, x);
         give_verdict();
      end
   endtask : wait_for

   task automatic t_idle;
      logic [31:0] q;
      int          n;
      wb(1'b1, `PMR_OFS_PCR, 32'h5, q);
      tick(1);
      chk("cpu_en", 32'(cpu_en), 32'h0);
      chk("per_en", 32'(per_en), 32'h1);
      chk("hold", {30'h0, st_hi, p_hold}, 32'h3);
      wb(1'b1, `PMR_OFS_PCR, 32'hA, q);
      wb(1'b1, 8'h0C, 32'hFF, q);
      wb(1'b0, 8'h0C, 32'h0, q);
      chk("unmapped", q, 32'h0);
      wb(1'b0, `PMR_OFS_PCR, 32'h0, q);
      chk("pcr idle", q, 32'h9);
      chk("cpu_en", 32'(cpu_en), 32'h0);
      @(posedge clk_i);
      irq <= 1'b1;
      wait_for(0, 1'b1, n);
      @(posedge clk_i);
      irq <= 1'b0;
      chk("idle exit", 32'(n <= 3), 32'h1);
      chk("strobe", 32'(st_hi), 32'h0);
      wb(1'b0, `PMR_OFS_PCR, 32'h0, q);
      chk("pcr exit", q, 32'h8);
   endtask : t_idle

   task automatic t_pdown;
      logic [31:0] q;
      int          n;
      wb(1'b1, `PMR_OFS_WAKE_EN, 32'h1, q);
      // Flag one rides along so the exit is seen to keep it
      wb(1'b1, `PMR_OFS_PCR, 32'hA, q);
      tick(2);
      chk("pd osc", {29'h0, osc_en, per_en, st_lo}, 32'h1);
      pmr_pins_model_i.pin_low(1, 20);
      tick(4);
      chk("no wake", 32'(osc_en), 32'h0);
      fork
         pmr_pins_model_i.pin_low(0, 40);
      join_none
      wait_for(1, 1'b1, n);
      chk("osc back", 32'(n <= 6), 32'h1);
      wait_for(0, 1'b1, n);
      chk("exit late", 32'(n >= 30), 32'h1);
      chk("wsrc", 32'(wsrc), 32'h1);
      wb(1'b0, `PMR_OFS_STATUS, 32'h0, q);
      chk("status", q, 32'h48);
      wb(1'b0, `PMR_OFS_PCR, 32'h0, q);
      chk("pcr", q, 32'h8);
      wb(1'b0, `PMR_OFS_WAKE_EN, 32'h0, q);
      chk("wen kept", q, 32'h1);
   endtask : t_pdown

   task automatic t_both;
      logic [31:0] q;
      int          n;
      wb(1'b1, `PMR_OFS_WAKE_EN, 32'h3, q);
      wb(1'b1, `PMR_OFS_PCR, 32'h2, q);
      tick(2);
      fork
         pmr_pins_model_i.pin_low(1, 20);
         begin
            tick(5);
            pmr_pins_model_i.pin_low(0, 40);
         end
      join_none
      wait_for(0, 1'b1, n);
      chk("first pin", 32'(n <= 30), 32'h1);
      chk("wsrc", 32'(wsrc), 32'h2);
      tick(40);
   endtask : t_both

   task automatic t_kbd;
      logic [31:0] q;
      int          n;
      wb(1'b1, `PMR_OFS_WAKE_EN, 32'h4, q);
      wb(1'b1, `PMR_OFS_PCR, 32'hB, q);
      fork
         pmr_pins_model_i.pin_low(2, 4);
      join_none
      wait_for(1, 1'b1, n);
      wait_for(0, 1'b1, n);
      chk("kbd wait", 32'(n >= KBD_N && n <= KBD_N + 2), 32'h1);
      chk("wsrc", 32'(wsrc), 32'h3);
      tick(3);
      chk("no idle", 32'(cpu_en), 32'h1);
      wb(1'b0, `PMR_OFS_PCR, 32'h0, q);
      chk("pcr", q, 32'h8);
   endtask : t_kbd

   task automatic t_warm;
      logic [31:0] q;
      logic        seen;
      int          n;
      wb(1'b1, `PMR_OFS_PCR, 32'h1, q);
      seen = 1'b0;
      fork
         pmr_pins_model_i.hold_reset(RST_N - 4);
      join_none
      repeat (RST_N + 6)
      begin
         tick(1);
         seen = seen | core_rst;
      end
      chk("short rst", 32'(seen), 32'h0);
      fork
         pmr_pins_model_i.hold_reset(RST_N);
      join_none
      wait_for(2, 1'b1, n);
      chk("rst delay", 32'(n <= RST_N + 5), 32'h1);
      wait_for(2, 1'b0, n);
      chk("cpu run", 32'(cpu_en), 32'h1);
      wb(1'b0, `PMR_OFS_PCR, 32'h0, q);
      chk("pcr rst", q, 32'h0);
      wb(1'b0, `PMR_OFS_WAKE_EN, 32'h0, q);
      chk("wen rst", q, 32'h0);
   endtask : t_warm

   task automatic t_wdt;
      logic seen;
      int   n;
      int   cnt;
      @(posedge clk_i);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
      // Drive starts at the edge that takes the fire, so count from there
      tick(0);
      cnt  = 0;
      seen = 1'b0;
      while (pin_oe === 1'b1 && pin_o === 1'b1 && cnt < 200)
      begin
         cnt++;
         seen = seen | core_rst;
         tick(1);
      end
      chk("wdt pulse", 32'(cnt), 32'(WDT_N));
      chk("wdt reset", 32'(seen), 32'h1);
      wait_for(2, 1'b0, n);
   endtask : t_wdt

   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_idle();
      t_pdown();
      t_both();
      t_kbd();
      t_warm();
      t_wdt();
      give_verdict();
   end
endmodule : pmr_top_bench
`default_nettype wire
